// [sec_fifo.sv]
`timescale 1ns/1ps
module sec_fifo
  import sec_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic mclk,         // System clock.
  input  wire logic reset,        // Synchronous reset.
  sec_fifo_if.store port          // Push and pop sides.
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0]   fill;
  logic             doPush;
  logic             doPop;

  assign doPush         = port.pushValid && port.pushReady;
  assign doPop          = port.popValid && port.popReady;
  assign port.pushReady = fill != (PTR_W+1)'(DEPTH);
  assign port.popValid  = fill != '0;
  assign port.popData   = slot[rdPtr];

  always_ff @(posedge mclk)
  begin
    if (doPush)
    begin
      slot[wrPtr] <= port.pushData;
    end
  end

  // Pointers wrap naturally, so DEPTH must be a power of two.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop)
      begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (doPush && !doPop)
      begin
        fill <= fill + 1'b1;
      end
      else if (doPop && !doPush)
      begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule

// [sec_fifo_if.sv]
`timescale 1ns/1ps
interface sec_fifo_if
  import sec_pkg::*;
#(
  parameter int WIDTH = ENTRY_W
)
();
  logic             pushValid;
  logic             pushReady;
  logic [WIDTH-1:0] pushData;
  logic             popValid;
  logic             popReady;
  logic [WIDTH-1:0] popData;

  modport fill  (output pushValid, output pushData, input pushReady);
  modport store (input pushValid, input pushData, output pushReady,
                 output popValid, output popData, input popReady);
  modport drain (input popValid, input popData, output popReady);
endinterface

// [sec_host_model.sv]
`timescale 1ns/1ps
module sec_host_model
  import sec_pkg::*;
(
  output logic              chipSelect,  // Select pin.
  output logic              serialClock, // Serial clock pin.
  output logic              serialData,  // Data toward the device.
  input  wire logic         serialDataOut, // Device data output.
  output logic [DATA_W:0]   readWord,    // Dummy bit and word read.
  output logic              readDone     // Pulse when readWord is new.
);
  // ----------------------------------------------------------------
  // Bit-level host
  // ----------------------------------------------------------------
  // Half of a 64 ns period; never a multiple of the system clock, so the
  // pins wander in phase against it as a real host would.
  localparam realtime HALF = 32.0;
  initial
  begin
    chipSelect = 1'b0;
    serialClock = 1'b0;
    serialData = 1'b0;
    readDone = 1'b0;
  end
  // A released line toggles every bit, so stale data never looks valid.
  task automatic shift(input logic drive, input logic b, output logic seen);
    serialData = drive ? b : ~serialData;
    #(HALF);
    serialClock = 1'b1;
    #(HALF);
    seen = serialDataOut;
    serialClock = 1'b0;
  endtask
  task automatic send(input int n, input logic [31:0] bits);
    logic s;
    for (int i = n - 1; i >= 0; i--)
      shift(1'b1, bits[i], s);
  endtask
  task automatic select(input logic v, input int halves);
    chipSelect = v;
    repeat (halves) #(HALF);
  endtask
  task automatic read_word(input logic [3:0] a);
    logic [DATA_W:0] w;
    send(7, {25'h0, 4'b1000, a[3:1]});
    shift(1'b1, a[0], w[DATA_W]);
    for (int i = DATA_W - 1; i >= 0; i--)
      shift(1'b0, 1'b0, w[i]);
    readWord = w;
    readDone = 1'b1;
    #1 readDone = 1'b0;
  endtask
endmodule

// [sec_pkg.sv]
package sec_pkg;

  // ----------------------------------------------------------------
  // Pins, array shape and command framing
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 3;
  localparam int PIN_CS   = 0;
  localparam int PIN_SK   = 1;
  localparam int PIN_DI   = 2;
  localparam int WORDS    = 16;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 16;
  localparam int CMD_W    = 8;
  localparam int OPC_MSB  = 6;
  localparam int OPC_LSB  = 4;
  localparam int HDR_LSB  = 3;

  localparam logic [4:0]  ADDR_LAST    = 5'h06;
  localparam logic [4:0]  SPECIAL_LAST = 5'h07;
  localparam logic [4:0]  DATA_LAST    = 5'h0f;
  localparam logic [4:0]  READ_LAST    = 5'h10;
  localparam logic [1:0]  SPECIAL_LEAD = 2'h3;
  localparam logic [2:0]  OP_READ      = 3'h0;
  localparam logic [2:0]  OP_WRITE     = 3'h4;
  localparam logic [2:0]  OP_ERASE     = 3'h2;
  localparam logic [4:0]  SPECIAL_HDR  = 5'h18;
  localparam logic [2:0]  TAIL_EN      = 3'h1;
  localparam logic [2:0]  TAIL_DIS     = 3'h2;
  localparam logic [2:0]  TAIL_WALL    = 3'h4;
  localparam logic [2:0]  TAIL_EALL    = 3'h5;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;

  // ----------------------------------------------------------------
  // Timing and buffering
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int PROG_TIME_US    = 10000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
  localparam int PROG_CNT_W      = 22;
  localparam int FIFO_DEPTH      = 32;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_OFF   = 7'h01,
    ST_START = 7'h02,
    ST_CMD   = 7'h04,
    ST_DATA  = 7'h08,
    ST_READ  = 7'h10,
    ST_ECHO  = 7'h20,
    ST_DONE  = 7'h40
  } sec_state_t;

  typedef enum logic [3:0] {
    CMD_MORE, CMD_NONE, CMD_READ, CMD_WRITE, CMD_ERASE,
    CMD_EN, CMD_DIS, CMD_WALL, CMD_EALL
  } sec_cmd_t;

  typedef enum logic [1:0] {
    PROG_WORD, PROG_ERASE, PROG_WALL, PROG_EALL
  } sec_prog_t;

  typedef struct packed {
    sec_prog_t          op;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } sec_entry_t;

  localparam int ENTRY_W = $bits(sec_entry_t);

endpackage

// [sec_port.sv]
`timescale 1ns/1ps
// Function
// - All bits move on serial clock rising edge; the echo copies data-in on every system clock instead.
// - Select rise, then data-in one is start.
// - One instruction per chip-select rising edge.
// - Read, write, erase codes carry 4-bit address.
// - Fixed codes enable and disable erase/write.
// - Fixed codes erase all and write all.
// - Read output: dummy zero, then 16 bits.
// - Data-in ignored during read and after command.
// - After 16 read bits, echo data-in out.
// - Output released unless selected in read mode.
// - Write: command, 16 bits, select low 10ms.
// - Erase kinds: command, then select low 10ms.
// - Select fall powers programming, rise stops it.
// - Programming completes with serial clock stopped.
// - Free-running serial clock never disturbs contents.
module sec_port
  import sec_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input  wire logic mclk,              // System clock, 200 MHz.
  input  wire logic reset,             // Synchronous reset.
  input  wire logic chipSelect,        // Chip select pin, high active.
  input  wire logic serial_clock_in,   // Serial clock pin.
  input  wire logic serial_data_in,    // Serial data input pin.
  output logic      serialDataOut,     // Serial data output value.
  output logic      serialDataOutEn,   // Data output drive enable.
  output logic      progVoltageOn,     // Programming voltage request.
  output logic      eraseWriteEnabled  // Erase/write unlocked.
);

  localparam logic [PROG_CNT_W-1:0] PROG_LAST =
    PROG_CNT_W'(PROG_CYCLES - 1);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] pinLevel;
  logic [NUM_PINS-1:0] pinRise;
  logic [NUM_PINS-1:0] pinFall;
  logic                csLvl;
  logic                csRise;
  logic                csFall;
  logic                skRise;
  logic                diLvl;

  assign pins[PIN_CS] = chipSelect;
  assign pins[PIN_SK] = serial_clock_in;
  assign pins[PIN_DI] = serial_data_in;

  sec_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .pinIn (pins),
    .level (pinLevel),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  assign csLvl  = pinLevel[PIN_CS];
  assign csRise = pinRise[PIN_CS];
  assign csFall = pinFall[PIN_CS];
  assign skRise = pinRise[PIN_SK] && pinLevel[PIN_CS];
  assign diLvl  = pinLevel[PIN_DI];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  sec_state_t        state;
  sec_cmd_t          cmdKind;
  logic [4:0]        bitCnt;
  logic [CMD_W-1:0]  shiftReg;
  logic [CMD_W-1:0]  cmdShift;
  logic [ADDR_W-1:0] cmdAddr;
  sec_prog_t         cmdOp;
  logic [DATA_W-1:0] dataReg;
  logic [DATA_W-1:0] readShift;
  logic              armed;
  logic              pushPend;
  logic              lastData;
  logic              progRun;
  logic              progDone;
  logic [PROG_CNT_W-1:0] progCnt;
  logic [DATA_W-1:0] mem [WORDS];
  sec_entry_t        head;

  assign cmdShift = {shiftReg[CMD_W-2:0], diLvl};
  assign lastData = state == ST_DATA && bitCnt == DATA_LAST;

  always_comb
  begin
    cmdKind = CMD_MORE;
    if (bitCnt == ADDR_LAST &&
        cmdShift[OPC_MSB:OPC_MSB-1] != SPECIAL_LEAD)
    begin
      case (cmdShift[OPC_MSB:OPC_LSB])
        OP_READ:  cmdKind = CMD_READ;
        OP_WRITE: cmdKind = CMD_WRITE;
        OP_ERASE: cmdKind = CMD_ERASE;
        default:  cmdKind = CMD_NONE;
      endcase
    end
    else if (bitCnt == SPECIAL_LAST)
    begin
      cmdKind = CMD_NONE;
      if (cmdShift[CMD_W-1:HDR_LSB] == SPECIAL_HDR)
      begin
        case (cmdShift[HDR_LSB-1:0])
          TAIL_EN:   cmdKind = CMD_EN;
          TAIL_DIS:  cmdKind = CMD_DIS;
          TAIL_WALL: cmdKind = CMD_WALL;
          TAIL_EALL: cmdKind = CMD_EALL;
          default:   cmdKind = CMD_NONE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------
  // Once a command has been taken, only a fresh select rise restarts.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= ST_OFF;
    end
    else if (csRise)
    begin
      state <= ST_START;
    end
    else if (!csLvl)
    begin
      state <= ST_OFF;
    end
    else if (skRise)
    begin
      unique case (state)
        ST_OFF:   state <= ST_OFF;
        ST_START:
        begin
          if (diLvl)
          begin
            state <= ST_CMD;
          end
        end
        ST_CMD:
        begin
          if (cmdKind == CMD_READ)
          begin
            state <= ST_READ;
          end
          else if (cmdKind == CMD_WRITE || cmdKind == CMD_WALL)
          begin
            state <= ST_DATA;
          end
          else if (cmdKind != CMD_MORE)
          begin
            state <= ST_DONE;
          end
        end
        ST_DATA:
        begin
          if (lastData)
          begin
            state <= ST_DONE;
          end
        end
        ST_READ:
        begin
          if (bitCnt == READ_LAST)
          begin
            state <= ST_ECHO;
          end
        end
        ST_ECHO:  state <= ST_ECHO;
        ST_DONE:  state <= ST_DONE;
        default:  state <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset || csRise)
    begin
      bitCnt   <= '0;
      shiftReg <= '0;
    end
    else if (skRise && state == ST_CMD)
    begin
      shiftReg <= cmdShift;
      bitCnt   <= (cmdKind == CMD_MORE) ? bitCnt + 5'h01 : 5'h00;
    end
    else if (skRise && (state == ST_DATA || state == ST_READ))
    begin
      bitCnt <= bitCnt + 5'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cmdAddr <= '0;
      cmdOp   <= PROG_WORD;
    end
    else if (skRise && state == ST_CMD)
    begin
      if (cmdKind == CMD_WRITE || cmdKind == CMD_ERASE ||
          cmdKind == CMD_READ)
      begin
        cmdAddr <= cmdShift[ADDR_W-1:0];
      end
      if (cmdKind == CMD_WRITE)
      begin
        cmdOp <= PROG_WORD;
      end
      else if (cmdKind == CMD_ERASE)
      begin
        cmdOp <= PROG_ERASE;
      end
      else if (cmdKind == CMD_WALL)
      begin
        cmdOp <= PROG_WALL;
      end
      else if (cmdKind == CMD_EALL)
      begin
        cmdOp <= PROG_EALL;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      dataReg <= '0;
    end
    else if (skRise && state == ST_DATA)
    begin
      dataReg <= {dataReg[DATA_W-2:0], diLvl};
    end
  end

  // Disabled from power-up so supply glitches cannot alter contents.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      eraseWriteEnabled <= 1'b0;
    end
    else if (skRise && state == ST_CMD)
    begin
      if (cmdKind == CMD_EN)
      begin
        eraseWriteEnabled <= 1'b1;
      end
      else if (cmdKind == CMD_DIS)
      begin
        eraseWriteEnabled <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset || csRise)
    begin
      armed <= 1'b0;
    end
    else if (skRise && eraseWriteEnabled &&
             ((state == ST_CMD &&
               (cmdKind == CMD_ERASE || cmdKind == CMD_EALL)) ||
              lastData))
    begin
      armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read data train
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      serialDataOut <= 1'b0;
      readShift     <= '0;
    end
    else if (skRise && state == ST_CMD && cmdKind == CMD_READ)
    begin
      readShift     <= mem[cmdShift[ADDR_W-1:0]];
      serialDataOut <= 1'b0;
    end
    else if (skRise && state == ST_READ && bitCnt != READ_LAST)
    begin
      serialDataOut <= readShift[DATA_W-1];
      readShift     <= {readShift[DATA_W-2:0], 1'b0};
    end
    else if (csLvl && state == ST_ECHO)
    begin
      serialDataOut <= diLvl;
    end
  end

  assign serialDataOutEn = state == ST_READ || state == ST_ECHO;

  // ----------------------------------------------------------------
  // Programming queue
  // ----------------------------------------------------------------
  sec_fifo_if #(
    .WIDTH (ENTRY_W)
  ) progQ ();

  sec_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk  (mclk),
    .reset (reset),
    .port  (progQ)
  );

  assign progQ.pushValid = pushPend;
  assign progQ.pushData  = {cmdOp, cmdAddr, dataReg};
  assign head            = sec_entry_t'(progQ.popData);

  // A pending push waits for queue space; a new select rise drops it.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      progVoltageOn <= 1'b0;
      pushPend      <= 1'b0;
    end
    else if (csRise)
    begin
      progVoltageOn <= 1'b0;
      pushPend      <= 1'b0;
    end
    else if (csFall && armed)
    begin
      progVoltageOn <= 1'b1;
      pushPend      <= 1'b1;
    end
    else if (pushPend && progQ.pushReady)
    begin
      pushPend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Programming engine
  // ----------------------------------------------------------------
  // Timed on the system clock alone, so a stopped serial clock is fine.
  assign progRun        = progQ.popValid && progVoltageOn;
  assign progDone       = progRun && progCnt == PROG_LAST;
  assign progQ.popReady = progDone || (progQ.popValid && !progVoltageOn);

  always_ff @(posedge mclk)
  begin
    if (reset || !progRun || progDone)
    begin
      progCnt <= '0;
    end
    else
    begin
      progCnt <= progCnt + 1'b1;
    end
  end

  // The array has no reset: its contents are meant to survive one.
  genvar w;
  generate
    for (w = 0; w < WORDS; w++)
    begin : g_word
      always_ff @(posedge mclk)
      begin
        if (progDone && (head.op == PROG_WALL || head.op == PROG_EALL ||
                         head.addr == ADDR_W'(w)))
        begin
          mem[w] <= (head.op == PROG_WORD || head.op == PROG_WALL) ?
                    head.data : ERASED_WORD;
        end
      end
    end
  endgenerate

endmodule

// [sec_port_assertions.sv]
`timescale 1ns/1ps
module sec_port_assertions
  import sec_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input wire logic mclk,              // System clock.
  input wire logic reset,             // Synchronous reset.
  input wire logic chipSelect,        // Chip select pin.
  input wire logic serial_clock_in,   // Serial clock pin.
  input wire logic serial_data_in,    // Serial data pin.
  input wire logic serialDataOut,     // Data output value.
  input wire logic serialDataOutEn,   // Data output enable.
  input wire logic progVoltageOn,     // Programming request.
  input wire logic eraseWriteEnabled  // Erase/write unlocked.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  // The pins are asynchronous, so each window allows for the two
  // synchroniser stages and the edge stage in front of the logic.
  oe_idle_a: assert property (!chipSelect [*8] |-> !serialDataOutEn)
    else $error("data output driven while unselected");
  oe_fall_a: assert property ($fell(chipSelect) |-> ##[1:8] !serialDataOutEn)
    else $error("data output not released after deselect");
  oe_start_a: assert property ($rose(serialDataOutEn) |-> !serialDataOut)
    else $error("read train does not begin with a zero");
  oe_sel_a: assert property ($rose(serialDataOutEn) |-> $past(chipSelect, 4))
    else $error("data output enabled without select");
  pv_off_a: assert property ($rose(chipSelect) |-> ##[1:8] !progVoltageOn)
    else $error("programming not stopped by select rise");
  pv_sel_a: assert property (chipSelect [*8] |-> !progVoltageOn)
    else $error("programming while selected");
  pv_start_a: assert property ($rose(progVoltageOn) |->
    !chipSelect && !$past(chipSelect, 2) && eraseWriteEnabled)
    else $error("programming started without locked-open low select");
  en_sel_a: assert property ($changed(eraseWriteEnabled) |->
    $past(chipSelect, 3))
    else $error("unlock flag moved without an instruction");
  en_idle_a: assert property (!chipSelect [*6] |=> $stable(eraseWriteEnabled))
    else $error("unlock flag moved while unselected");
  read_c: cover property ($rose(serialDataOutEn));
  prog_c: cover property ($rose(progVoltageOn));
  unlock_c: cover property ($rose(eraseWriteEnabled));
endmodule

bind sec_port sec_port_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .mclk(mclk), .reset(reset), .chipSelect(chipSelect),
  .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
  .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
  .progVoltageOn(progVoltageOn), .eraseWriteEnabled(eraseWriteEnabled));

// [sec_port_test.sv]
`timescale 1ns/1ps
module sec_port_test;
  import sec_pkg::*;
  localparam int PROG = 50;
  logic              mclk;
  logic              reset;
  logic              chipSelect;
  logic              serialClock;
  logic              serialData;
  logic              serialDataOut;
  logic              serialDataOutEn;
  logic              dataLine;
  logic              progVoltageOn;
  logic              eraseWriteEnabled;
  logic [DATA_W:0]   readWord;
  logic              readDone;
  logic [DATA_W-1:0] expQ[$];
  logic [DATA_W-1:0] w0;
  logic [DATA_W-1:0] wa;
  logic [31:0]       rnd = 32'h28;
  logic              s;
  int                errors = 0;
  int                num_checks = 0;
  sec_port #(.PROG_CYCLES(PROG)) u_sec_port (
    .mclk(mclk), .reset(reset), .chipSelect(chipSelect),
    .serial_clock_in(serialClock), .serial_data_in(serialData),
    .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
    .progVoltageOn(progVoltageOn), .eraseWriteEnabled(eraseWriteEnabled));
  sec_host_model u_sec_host_model (
    .chipSelect(chipSelect), .serialClock(serialClock),
    .serialData(serialData), .serialDataOut(dataLine),
    .readWord(readWord), .readDone(readDone));
  // An undriven line has no pull, so show the inverse and let a stale
  // bit fail instead of passing by luck.
  assign dataLine = serialDataOutEn ? serialDataOut : ~serialDataOut;
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic check_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic check_word(input string n, input logic [DATA_W-1:0] e,
                            input logic [DATA_W-1:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge readDone)
  begin
    check_bit("dummy", 1'b0, readWord[DATA_W]);
    if (expQ.size() == 0)
      check_bit("readQueue", 1'b0, 1'b1);
    else
      check_word("readWord", expQ.pop_front(), readWord[DATA_W-1:0]);
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    errors++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Instructions
  // ----------------------------------------------------------------
  // Select held low for low cycles after the bits, then a select pulse.
  task automatic instr(input int n, input logic [31:0] bits, input int low,
                       input logic pv);
    @(negedge mclk);
    u_sec_host_model.select(1'b1, 2);
    u_sec_host_model.send(n, bits);
    check_bit("serialDataOutEn", 1'b0, serialDataOutEn);
    u_sec_host_model.select(1'b0, 0);
    repeat (low) @(negedge mclk);
    check_bit("progVoltageOn", pv, progVoltageOn);
    u_sec_host_model.select(1'b1, 2);
    check_bit("progVoltageOn", 1'b0, progVoltageOn);
    u_sec_host_model.select(1'b0, 2);
  endtask
  task automatic rd(input logic [3:0] a, input logic [DATA_W-1:0] e,
                    input int echoes);
    logic b;
    expQ.push_back(e);
    @(negedge mclk);
    u_sec_host_model.select(1'b1, 2);
    u_sec_host_model.read_word(a);
    check_bit("serialDataOutEn", 1'b1, serialDataOutEn);
    for (int i = 0; i < echoes; i++)
    begin
      b = 1'(xs());
      u_sec_host_model.shift(1'b1, b, s);
      check_bit("echo", b, s);
    end
    u_sec_host_model.select(1'b0, 2);
    check_bit("serialDataOutEn", 1'b0, serialDataOutEn);
  endtask
  initial
  begin
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    check_bit("eraseWriteEnabled", 1'b0, eraseWriteEnabled);
    instr(9, 9'h1c5, 2 * PROG, 1'b0);
    instr(9, 9'h1c1, 4, 1'b0);
    check_bit("eraseWriteEnabled", 1'b1, eraseWriteEnabled);
    instr(9, 9'h1c5, 2 * PROG, 1'b1);
    for (int a = 0; a < WORDS; a++)
      rd(a[3:0], 16'hffff, 0);
    w0 = 16'(xs());
    wa = 16'(xs());
    instr(24, {4'b1100, 4'h0, w0}, 2 * PROG, 1'b1);
    instr(24, {4'b1100, 4'hf, wa}, 2 * PROG, 1'b1);
    rd(4'h0, w0, 4);
    rd(4'hf, wa, 0);
    instr(8, {4'b1010, 4'hf}, 2 * PROG, 1'b1);
    rd(4'hf, 16'hffff, 0);
    rd(4'h0, w0, 0);
    instr(9, 9'h1c2, 4, 1'b0);
    check_bit("eraseWriteEnabled", 1'b0, eraseWriteEnabled);
    @(negedge mclk);
    u_sec_host_model.select(1'b1, 2);
    u_sec_host_model.send(9, 9'h1c2);
    u_sec_host_model.send(9, 9'h1c1);
    u_sec_host_model.select(1'b0, 2);
    check_bit("eraseWriteEnabled", 1'b0, eraseWriteEnabled);
    instr(24, {4'b1100, 4'h0, ~w0}, 2 * PROG, 1'b0);
    for (int i = 0; i < 20; i++)
      u_sec_host_model.shift(1'b1, 1'(xs()), s);
    rd(4'h0, w0, 0);
    instr(9, 9'h1c1, 4, 1'b0);
    wa = 16'(xs());
    instr(25, {9'h1c4, wa}, 2 * PROG, 1'b1);
    rd(4'h7, wa, 0);
    rd(4'h0, wa, 0);
    instr(24, {4'b1100, 4'h3, ~wa}, PROG / 2, 1'b1);
    rd(4'h3, wa, 0);
    instr(9, 9'h1c2, 4, 1'b0);
    check_bit("eraseWriteEnabled", 1'b0, eraseWriteEnabled);
    repeat (10) @(negedge mclk);
    complete_run();
  end
endmodule

// [sec_sync.sv]
`timescale 1ns/1ps
module sec_sync
  import sec_pkg::*;
#(
  parameter int WIDTH = NUM_PINS
)
(
  input  wire logic             mclk,   // System clock.
  input  wire logic             reset,  // Synchronous reset.
  input  wire logic [WIDTH-1:0] pinIn,  // Pins from outside.
  output logic      [WIDTH-1:0] level,  // Synchronised level.
  output logic      [WIDTH-1:0] rise,   // One-cycle rising edge.
  output logic      [WIDTH-1:0] fall    // One-cycle falling edge.
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      logic meta;
      logic stable;
      logic prev;
      // Only the second stage and later are looked at by any logic.
      always_ff @(posedge mclk)
      begin
        if (reset)
        begin
          meta   <= 1'b0;
          stable <= 1'b0;
          prev   <= 1'b0;
        end
        else
        begin
          meta   <= pinIn[i];
          stable <= meta;
          prev   <= stable;
        end
      end
      assign level[i] = stable;
      assign rise[i]  = stable & ~prev;
      assign fall[i]  = ~stable & prev;
    end
  endgenerate

endmodule
